/* hdl/rt_pkg.sv */
// rt_pkg: shared constants and types for the relink and test mode control
// assumes: 8-bit device register port, 32-bit AXI4-Lite on the controller
package rt_pkg;
   // ****************************************
   // device register offsets
   // ****************************************
   localparam logic [7:0] RT_A_LINK_MODE = 8'h30;
   localparam logic [7:0] RT_A_RX_STATUS = 8'h31;
   localparam logic [7:0] RT_A_AUDIO_FMT = 8'h32;
   localparam logic [7:0] RT_A_TX_PWR = 8'h33;
   localparam logic [7:0] RT_A_RX_PWR = 8'h34;
   localparam logic [7:0] RT_A_REM_EXEC = 8'h35;
   localparam logic [7:0] RT_A_TX_UPD = 8'h5b;
   localparam logic [7:0] RT_A_LNK_UPD = 8'h3e;
   localparam logic [7:0] RT_A_RX_UPD = 8'h4b;
   localparam logic [7:0] RT_A_TEST_CODE = 8'h7e;
   localparam logic [7:0] RT_A_TEST_CHAN = 8'h7f;
   // ****************************************
   // fields, codes, reset values
   // ****************************************
   localparam int RT_B_FORCE = 4;
   localparam int RT_B_SLAVE_DIS = 6;
   localparam int RT_B_TEST_TX = 7;
   localparam logic [7:0] RT_TC_SINGLE = 8'h63;
   localparam logic [7:0] RT_TC_SWEEP = 8'h73;
   localparam logic [7:0] RT_UPD_IDLE = 8'h00;
   localparam logic [7:0] RT_UPD_START = 8'h01;
   localparam logic [7:0] RT_UPD_FAIL = 8'h02;
   localparam logic [7:0] RT_RST_BYTE = 8'h00;
   localparam logic [1:0] RT_PWR_0DBM = 2'h3;
   localparam int RT_F_BASE_MHZ = 2400;
   localparam int RT_F_TOP_MHZ = 2480;
   localparam logic [6:0] RT_SWEEP_LAST = 7'(RT_F_TOP_MHZ - RT_F_BASE_MHZ);
   localparam int RT_CLK_MHZ = 100;
   localparam int RT_DWELL_US = 1;
   localparam logic [6:0] RT_DWELL_CYC = 7'(RT_DWELL_US * RT_CLK_MHZ - 1);
   // ****************************************
   // controller register map (AXI byte addresses)
   // ****************************************
   localparam logic [3:0] RT_C_CMD = 4'h0;
   localparam logic [3:0] RT_C_STAT = 4'h4;
   localparam logic [3:0] RT_C_TEST = 4'h8;
   localparam logic [1:0] RT_RESP_OK = 2'h0;
   localparam logic [1:0] RT_RESP_ERR = 2'h2;
   localparam logic [1:0] RT_OP_WRITE = 2'h0;
   localparam logic [1:0] RT_OP_READ = 2'h1;
   localparam logic [1:0] RT_OP_SAFE_UPD = 2'h2;
   localparam logic [1:0] RT_OP_TEST = 2'h3;
   typedef enum logic [2:0] {
      RT_IDLE = 3'h0, RT_LOCATE = 3'h1, RT_RECONF = 3'h3,
      RT_STREAM = 3'h2, RT_TEST = 3'h6
   } rt_dev_state_e;
   typedef enum logic [1:0] {
      RT_C_IDLE = 2'h0, RT_C_REQ = 2'h1, RT_C_GAP = 2'h3
   } rt_ctl_state_e;
endpackage : rt_pkg

/* hdl/rt_if.sv */
// rt_if: register port between the controller and the transceiver
// assumes: both ends on sys_clk; req held until a one-cycle ack
`timescale 1ns/1ps
interface rt_if;
   logic req;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   modport ctl (output req, we, addr, wdata, input ack, rdata);
   modport dev (input req, we, addr, wdata, output ack, rdata);
endinterface : rt_if

/* hdl/rt_upd.sv */
// rt_upd: one settings-update register (idle, busy, failed)
// assumes: start is a one-cycle write strobe of the start code
`timescale 1ns/1ps
module rt_upd (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic start,
   input wire logic done,
   input wire logic fail,
   output logic [7:0] status,
   output logic sendStart
);
   import rt_pkg::*;
   typedef struct packed {
      logic [7:0] status;
      logic sendStart;
   } rt_upd_s;
   rt_upd_s st_r;
   rt_upd_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.sendStart = 1'b0;
      if (st_r.status == RT_UPD_START) begin
         if (fail) begin
            st_nxt.status = RT_UPD_FAIL;
         end else if (done) begin
            st_nxt.status = RT_UPD_IDLE;
         end
      end else if (start) begin
         // a start while busy is dropped: values may not change mid-send
         st_nxt.status = RT_UPD_START;
         st_nxt.sendStart = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign status = st_r.status;
   assign sendStart = st_r.sendStart;
endmodule : rt_upd

/* hdl/rt_dev.sv */
// rt_dev: transceiver end - relink, auto-send and test mode control
// assumes: radio, eeprom loader and audio path sit outside and report
// through the plain ports; controller reaches registers over rt_if
`timescale 1ns/1ps
module rt_dev (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic ce,
   rt_if.dev bus,
   input wire logic roleRx,
   input wire logic linkFound,
   input wire logic linkLost,
   input wire logic eepLoad,
   input wire logic eepAbort,
   input wire logic [7:0] eepStatus,
   input wire logic [2:0] xferDone,
   input wire logic [2:0] xferFail,
   input wire logic remRspValid,
   input wire logic [7:0] remRspData,
   output logic reconfigPulse,
   output logic [7:0] fmtActive,
   output logic sendRate,
   output logic sendRxMode,
   output logic sendPins,
   output logic streaming,
   output logic testActive,
   output logic testTx,
   output logic [6:0] testChannel,
   output logic [1:0] radioPwr,
   output logic [2:0] updStart,
   output logic remStart,
   output logic [7:0] remData,
   output logic slaveEn
);
   import rt_pkg::*;
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      rt_dev_state_e st;
      logic ack;
      logic [7:0] rdata;
      logic strapDone;
      logic isRx;
      logic [7:0] linkMode;
      logic [7:0] rxStatus;
      logic [7:0] fmtShadow;
      logic [7:0] fmtActive;
      logic [7:0] transmit_power_setting;
      logic [7:0] receiver_power_setting;
      logic [7:0] testCode;
      logic [7:0] testChan;
      logic testSweep;
      logic testTx;
      logic [6:0] chan;
      logic [6:0] dwell;
      logic [1:0] pwr;
      logic reconf;
      logic sendRate;
      logic sendRxMode;
      logic sendPins;
      logic remStart;
      logic [7:0] remData;
      logic slaveEn;
   } rt_dev_s;
   rt_dev_s s_r;
   rt_dev_s s_nxt;
   logic [2:0] updWr;
   logic [7:0] updStat [3];
   logic acc;
   logic wr;

   function automatic logic testCodeOk(input logic [7:0] code);
      testCodeOk = (code == RT_TC_SINGLE) || (code == RT_TC_SWEEP);
   endfunction : testCodeOk

   function automatic logic isUpd(input logic [7:0] a, input int i);
      case (i)
         0: isUpd = (a == RT_A_TX_UPD);
         1: isUpd = (a == RT_A_LNK_UPD);
         default: isUpd = (a == RT_A_RX_UPD);
      endcase
   endfunction : isUpd

   // no slave interface at all while disabled: requests get no ack
   assign acc = bus.req && !s_r.ack && s_r.slaveEn;
   assign wr = acc && bus.we;

   // ****************************************
   // update registers
   // ****************************************
   // rx update carries rx control regs only; receiver mode goes by locate
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_upd
         assign updWr[gi] = wr && isUpd(bus.addr, gi)
            && (bus.wdata == RT_UPD_START);
         rt_upd u_upd (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .ce(ce),
            .start(updWr[gi]),
            .done(xferDone[gi]),
            .fail(xferFail[gi]),
            .status(updStat[gi]),
            .sendStart(updStart[gi])
         );
      end
   endgenerate

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.reconf = 1'b0;
      s_nxt.remStart = 1'b0;
      // strap caught on the first enabled edge after reset release
      if (!s_r.strapDone) begin
         s_nxt.strapDone = 1'b1;
         s_nxt.isRx = roleRx;
      end
      // register port
      if (acc) begin
         s_nxt.ack = 1'b1;
         s_nxt.rdata = RT_RST_BYTE;
         if (bus.we) begin
            if (bus.addr == RT_A_LINK_MODE) begin
               s_nxt.linkMode = bus.wdata;
            end else if (bus.addr == RT_A_RX_STATUS) begin
               // slave-disable bit is not writable over the slave port
               s_nxt.rxStatus = {s_r.rxStatus[7],
                  s_r.rxStatus[RT_B_SLAVE_DIS], bus.wdata[5:0]};
            end else if (bus.addr == RT_A_AUDIO_FMT) begin
               s_nxt.fmtShadow = bus.wdata;
            end else if (bus.addr == RT_A_TX_PWR) begin
               s_nxt.transmit_power_setting = bus.wdata;
            end else if (bus.addr == RT_A_RX_PWR) begin
               s_nxt.receiver_power_setting = bus.wdata;
            end else if (bus.addr == RT_A_REM_EXEC) begin
               s_nxt.remData = bus.wdata;
               s_nxt.remStart = 1'b1;
            end else if (bus.addr == RT_A_TEST_CODE) begin
               if (s_r.st != RT_TEST) begin
                  s_nxt.testCode = bus.wdata;
               end
            end else if (bus.addr == RT_A_TEST_CHAN) begin
               if (s_r.st != RT_TEST) begin
                  s_nxt.testChan = bus.wdata;
               end
            end
         end else begin
            if (bus.addr == RT_A_LINK_MODE) begin
               s_nxt.rdata = s_r.linkMode;
            end else if (bus.addr == RT_A_RX_STATUS) begin
               s_nxt.rdata = s_r.rxStatus;
            end else if (bus.addr == RT_A_AUDIO_FMT) begin
               s_nxt.rdata = s_r.fmtShadow;
            end else if (bus.addr == RT_A_TX_PWR) begin
               s_nxt.rdata = s_r.transmit_power_setting;
            end else if (bus.addr == RT_A_RX_PWR) begin
               s_nxt.rdata = s_r.receiver_power_setting;
            end else if (bus.addr == RT_A_REM_EXEC) begin
               s_nxt.rdata = s_r.remData;
            end else if (bus.addr == RT_A_TX_UPD) begin
               s_nxt.rdata = updStat[0];
            end else if (bus.addr == RT_A_LNK_UPD) begin
               s_nxt.rdata = updStat[1];
            end else if (bus.addr == RT_A_RX_UPD) begin
               s_nxt.rdata = updStat[2];
            end
         end
      end
      if (remRspValid) begin
         s_nxt.remData = remRspData;
      end
      // eeprom load: abort leaves rxStatus, disable bit included, as it was
      if (eepLoad && !eepAbort && s_r.isRx) begin
         s_nxt.rxStatus = eepStatus;
      end
      s_nxt.slaveEn = !(s_r.isRx && s_nxt.rxStatus[RT_B_SLAVE_DIS]);
      // link sequence
      case (s_r.st)
         RT_IDLE: begin
            if (s_r.strapDone) begin
               s_nxt.st = RT_LOCATE;
            end
         end
         RT_LOCATE: begin
            if (linkFound) begin
               s_nxt.st = RT_RECONF;
            end
         end
         RT_RECONF: begin
            s_nxt.fmtActive = s_r.fmtShadow;
            s_nxt.reconf = 1'b1;
            s_nxt.st = RT_STREAM;
         end
         RT_STREAM: begin
            if (linkLost) begin
               s_nxt.st = RT_LOCATE;
            end
         end
         RT_TEST: begin
            // only arst_n leaves this state
            if (s_r.testSweep) begin
               if (s_r.dwell == RT_DWELL_CYC) begin
                  s_nxt.dwell = '0;
                  s_nxt.chan = (s_r.chan == RT_SWEEP_LAST) ? '0
                     : 7'(s_r.chan + 7'h1);
               end else begin
                  s_nxt.dwell = 7'(s_r.dwell + 7'h1);
               end
            end
         end
         default: begin
            s_nxt.st = RT_IDLE;
         end
      endcase
      // forced relink: pending until it starts, then dropped
      if (s_r.st != RT_TEST && s_r.st != RT_IDLE
            && s_r.linkMode[RT_B_FORCE]) begin
         s_nxt.linkMode[RT_B_FORCE] &= wr
            && bus.addr == RT_A_LINK_MODE;
         if (testCodeOk(s_r.testCode)) begin
            s_nxt.st = RT_TEST;
            s_nxt.testSweep = (s_r.testCode == RT_TC_SWEEP);
            s_nxt.testTx = s_r.testChan[RT_B_TEST_TX];
            s_nxt.chan = s_nxt.testSweep ? '0 : s_r.testChan[6:0];
            s_nxt.dwell = '0;
         end else begin
            s_nxt.st = RT_LOCATE;
         end
      end
      // auto-send: hop table never part of it, each side loads its own
      s_nxt.sendRate = (s_nxt.st == RT_LOCATE) && !s_r.isRx;
      s_nxt.sendRxMode = (s_nxt.st == RT_LOCATE) && !s_r.isRx;
      s_nxt.sendPins = s_r.isRx && (s_nxt.st == RT_LOCATE
         || s_nxt.st == RT_STREAM || s_nxt.st == RT_RECONF);
      if (s_nxt.st == RT_TEST) begin
         s_nxt.pwr = RT_PWR_0DBM;
      end else begin
         s_nxt.pwr = s_r.isRx ? s_r.receiver_power_setting[1:0] : s_r.transmit_power_setting[1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
         s_r.slaveEn <= 1'b1;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign bus.ack = s_r.ack;
   assign bus.rdata = s_r.rdata;
   assign reconfigPulse = s_r.reconf;
   assign fmtActive = s_r.fmtActive;
   assign sendRate = s_r.sendRate;
   assign sendRxMode = s_r.sendRxMode;
   assign sendPins = s_r.sendPins;
   assign streaming = (s_r.st == RT_STREAM);
   assign testActive = (s_r.st == RT_TEST);
   assign testTx = s_r.testTx;
   assign testChannel = s_r.chan;
   assign radioPwr = s_r.pwr;
   assign remStart = s_r.remStart;
   assign remData = s_r.remData;
   assign slaveEn = s_r.slaveEn;
endmodule : rt_dev

/* hdl/rt_ctl.sv */
// rt_ctl: controller end - AXI4-Lite command registers to rt_if accesses
// assumes: one AXI write and one read at a time; device acks each request
`timescale 1ns/1ps
module rt_ctl (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic ce,
   rt_if.ctl bus,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import rt_pkg::*;
   typedef struct packed {
      logic awRdy, wRdy, awHave, wHave, bValid, arRdy, rValid;
      logic [3:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic [1:0] bResp, rResp;
      logic [31:0] rData;
      logic [31:0] cmd;
      logic [31:0] test;
      rt_ctl_state_e st;
      logic [1:0] step;
      logic [7:0] lastRd;
      logic req, we;
      logic [7:0] addr, data;
   } rt_ctl_s;
   rt_ctl_s s_r;
   rt_ctl_s s_nxt;
   logic last;

   function automatic logic [31:0] merge(input logic [31:0] o,
         input logic [31:0] n, input logic [3:0] b);
      for (int i = 0; i < 4; i++) begin
         o[i*8 +: 8] = b[i] ? n[i*8 +: 8] : o[i*8 +: 8];
      end
      merge = o;
   endfunction : merge

   // one access of an operation: {we, addr, data}
   function automatic logic [16:0] access(input logic [31:0] c,
         input logic [31:0] t, input logic [1:0] step);
      case (c[1:0])
         RT_OP_READ: access = {1'b0, c[15:8], 8'h00};
         RT_OP_SAFE_UPD: access = (step == 2'h0) ? {1'b0, c[15:8], 8'h00}
            : {1'b1, c[15:8], RT_UPD_START};
         RT_OP_TEST: begin
            if (step == 2'h0) begin
               access = {1'b1, RT_A_TEST_CODE, t[7:0]};
            end else if (step == 2'h1) begin
               access = {1'b1, RT_A_TEST_CHAN, t[15:8]};
            end else begin
               access = {1'b1, RT_A_LINK_MODE, 8'(1 << RT_B_FORCE)};
            end
         end
         default: access = {1'b1, c[15:8], c[23:16]};
      endcase
   endfunction : access

   assign last = (s_r.cmd[1:0] == RT_OP_TEST) ? (s_r.step == 2'h2)
      : (s_r.cmd[1:0] == RT_OP_SAFE_UPD) ? (s_r.step == 2'h1) : 1'b1;

   always_comb begin
      s_nxt = s_r;
      // ****************************************
      // AXI4-Lite write channel
      // ****************************************
      if (s_axi_awvalid && s_r.awRdy) begin
         s_nxt.awHave = 1'b1;
         s_nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_r.wRdy) begin
         s_nxt.wHave = 1'b1;
         s_nxt.wData = s_axi_wdata;
         s_nxt.wStrb = s_axi_wstrb;
      end
      if (s_r.bValid && s_axi_bready) begin
         s_nxt.bValid = 1'b0;
      end
      if (s_r.awHave && s_r.wHave && !s_r.bValid) begin
         s_nxt.awHave = 1'b0;
         s_nxt.wHave = 1'b0;
         s_nxt.bValid = 1'b1;
         s_nxt.bResp = RT_RESP_OK;
         if ({s_r.awAddr[3:2], 2'h0} == RT_C_CMD) begin
            // commands while busy are dropped
            if (s_r.st == RT_C_IDLE) begin
               s_nxt.cmd = merge(s_r.cmd, s_r.wData, s_r.wStrb);
               s_nxt.st = RT_C_GAP;
               s_nxt.step = 2'h0;
            end
         end else if ({s_r.awAddr[3:2], 2'h0} == RT_C_TEST) begin
            s_nxt.test = merge(s_r.test, s_r.wData, s_r.wStrb);
         end else if ({s_r.awAddr[3:2], 2'h0} != RT_C_STAT) begin
            s_nxt.bResp = RT_RESP_ERR;
         end
      end
      s_nxt.awRdy = !s_nxt.awHave && !s_nxt.bValid;
      s_nxt.wRdy = !s_nxt.wHave && !s_nxt.bValid;
      // ****************************************
      // AXI4-Lite read channel
      // ****************************************
      if (s_r.rValid && s_axi_rready) begin
         s_nxt.rValid = 1'b0;
      end
      if (s_axi_arvalid && s_r.arRdy) begin
         s_nxt.rValid = 1'b1;
         s_nxt.rResp = RT_RESP_OK;
         if ({s_axi_araddr[3:2], 2'h0} == RT_C_CMD) begin
            s_nxt.rData = s_r.cmd;
         end else if ({s_axi_araddr[3:2], 2'h0} == RT_C_STAT) begin
            s_nxt.rData = {16'h0000, s_r.lastRd, 7'h00,
               s_r.st != RT_C_IDLE};
         end else if ({s_axi_araddr[3:2], 2'h0} == RT_C_TEST) begin
            s_nxt.rData = s_r.test;
         end else begin
            s_nxt.rData = 32'h0000_0000;
            s_nxt.rResp = RT_RESP_ERR;
         end
      end
      s_nxt.arRdy = !s_nxt.rValid;
      // ****************************************
      // device access sequencer
      // ****************************************
      case (s_r.st)
         RT_C_GAP: begin
            {s_nxt.we, s_nxt.addr, s_nxt.data} =
               access(s_r.cmd, s_r.test, s_r.step);
            s_nxt.req = 1'b1;
            s_nxt.st = RT_C_REQ;
         end
         RT_C_REQ: begin
            if (bus.ack) begin
               s_nxt.req = 1'b0;
               if (!s_r.we) begin
                  s_nxt.lastRd = bus.rdata;
               end
               if (s_r.cmd[1:0] == RT_OP_SAFE_UPD && !s_r.we
                     && bus.rdata == RT_UPD_START) begin
                  s_nxt.st = RT_C_GAP;
               end else if (last) begin
                  s_nxt.st = RT_C_IDLE;
               end else begin
                  s_nxt.step = 2'(s_r.step + 2'h1);
                  s_nxt.st = RT_C_GAP;
               end
            end
         end
         default: begin
            s_nxt.req = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
         s_r.awRdy <= 1'b1;
         s_r.wRdy <= 1'b1;
         s_r.arRdy <= 1'b1;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign bus.req = s_r.req;
   assign bus.we = s_r.we;
   assign bus.addr = s_r.addr;
   assign bus.wdata = s_r.data;
   assign s_axi_awready = s_r.awRdy;
   assign s_axi_wready = s_r.wRdy;
   assign s_axi_bresp = s_r.bResp;
   assign s_axi_bvalid = s_r.bValid;
   assign s_axi_arready = s_r.arRdy;
   assign s_axi_rdata = s_r.rData;
   assign s_axi_rresp = s_r.rResp;
   assign s_axi_rvalid = s_r.rValid;
endmodule : rt_ctl

/* bench/rt_monitor.sv */
// rt_monitor: checks on the rt_if register port
// assumes: both ends on sys_clk, transceiver slave enabled
`timescale 1ns/1ps
module rt_monitor
   import rt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence s_hs; req && !ack ##1 ack; endsequence
   sequence s_code; req && we && addr == RT_A_TEST_CODE ##1 ack; endsequence
   sequence s_chan; req && we && addr == RT_A_TEST_CHAN ##1 ack; endsequence
   property p_one; ack |=> !ack; endproperty
   property p_take; $rose(req) |=> ack; endproperty
   property p_cause; ack |-> req; endproperty
   property p_hold; req && !ack |=> req && $stable({we, addr, wdata});
   endproperty
   property p_drop; s_hs |=> !req; endproperty
   property p_rd; !req |=> $stable(rdata); endproperty
   property p_order;
      s_code |-> ##[2:12] req && we && addr == RT_A_TEST_CHAN;
   endproperty
   // test settings must be in place before the force bit lands
   property p_force; s_chan |-> ##[2:12] req && we &&
      addr == RT_A_LINK_MODE && wdata[RT_B_FORCE]; endproperty
   a_one: assert property (p_one)
      else $error("ack longer than a cycle");
   a_take: assert property (p_take)
      else $error("request not acked");
   a_cause: assert property (p_cause)
      else $error("ack without request");
   a_hold: assert property (p_hold)
      else $error("request changed before ack");
   a_drop: assert property (p_drop)
      else $error("request kept after ack");
   a_rd: assert property (p_rd)
      else $error("read data moved while idle");
   a_order: assert property (p_order)
      else $error("test channel write missing");
   a_force: assert property (p_force)
      else $error("force bit write missing");
endmodule : rt_monitor

/* bench/testbench.sv */
// testbench: rt_ctl and rt_dev joined on rt_if, driven over AXI4-Lite
// assumes: transceiver strapped as transmitter, no eeprom fitted
`timescale 1ns/1ps
module testbench;
   import rt_pkg::*;
   logic sys_clk = 1'h0, arst_n = 1'h0, ce = 1'h1, roleRx = 1'h0;
   logic linkFound = 1'h0, linkLost = 1'h0, eepLoad = 1'h0;
   logic eepAbort = 1'h0, remRspValid = 1'h0;
   logic [7:0] eepStatus = 8'h0, remRspData = 8'h0, fmtActive, remData, b;
   logic [2:0] xferDone = 3'h0, xferFail = 3'h0, updStart;
   logic reconfigPulse, sendRate, sendRxMode, sendPins, streaming;
   logic testActive, testTx, remStart, slaveEn;
   logic [6:0] testChannel, c;
   logic [1:0] radioPwr, s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   int fails = 0, checks = 0, updCnt = 0;
   rt_if bus();
   rt_ctl rt_ctl_i (.sys_clk, .arst_n, .ce, .bus(bus.ctl), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   rt_dev rt_dev_i (.sys_clk, .arst_n, .ce, .bus(bus.dev), .roleRx,
      .linkFound, .linkLost, .eepLoad, .eepAbort, .eepStatus, .xferDone,
      .xferFail, .remRspValid, .remRspData, .reconfigPulse, .fmtActive,
      .sendRate, .sendRxMode, .sendPins, .streaming, .testActive, .testTx,
      .testChannel, .radioPwr, .updStart, .remStart, .remData, .slaveEn);
   rt_monitor rt_monitor_i (.sys_clk, .arst_n, .req(bus.req), .we(bus.we),
      .addr(bus.addr), .wdata(bus.wdata), .ack(bus.ack), .rdata(bus.rdata));
   initial forever #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) updCnt <= updCnt + updStart[0];
   task automatic chk(input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic axiW(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'h1;
      s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask : axiW
   task automatic axiR(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'h0;
   endtask : axiR
   // busy polling keeps commands from being dropped silently
   task automatic cmd(input logic [1:0] op, input logic [7:0] a, d);
      logic [31:0] s;
      logic [1:0] r;
      axiW(RT_C_CMD, {8'h0, d, a, 6'h0, op});
      do axiR(RT_C_STAT, s, r); while (s[0] !== 1'h0);
      b = s[15:8];
   endtask : cmd
   task automatic waitTest;
      for (int i = 0; i < 60 && testActive !== 1'h1; i++) @(posedge sys_clk);
   endtask : waitTest
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      chk(sendRate, 1'h1);
      chk(sendRxMode, 1'h1);
      axiR(4'hc, d, r);
      chk(r, RT_RESP_ERR);
      chk(d, 32'h0);
      linkFound <= 1'h1;
      repeat (3) @(posedge sys_clk) linkFound <= 1'h0;
      chk(reconfigPulse, 1'h1);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_upd;
      cmd(RT_OP_SAFE_UPD, RT_A_TX_UPD, RT_UPD_START);
      chk(updCnt, 1);
      cmd(RT_OP_READ, RT_A_TX_UPD, 8'h0);
      chk(b, RT_UPD_START);
      @(posedge sys_clk) xferFail <= 3'h1;
      @(posedge sys_clk) xferFail <= 3'h0;
      cmd(RT_OP_READ, RT_A_TX_UPD, 8'h0);
      chk(b, RT_UPD_FAIL);
      cmd(RT_OP_SAFE_UPD, RT_A_TX_UPD, RT_UPD_START);
      chk(updCnt, 2);
      @(posedge sys_clk) xferDone <= 3'h1;
      @(posedge sys_clk) xferDone <= 3'h0;
      cmd(RT_OP_READ, RT_A_TX_UPD, 8'h0);
      chk(b, RT_UPD_IDLE);
      cmd(RT_OP_WRITE, RT_A_REM_EXEC, 8'h5a);
      chk(remData, 8'h5a);
      @(posedge sys_clk) remRspValid <= 1'h1;
      remRspData <= 8'hc3;
      @(posedge sys_clk) remRspValid <= 1'h0;
      @(posedge sys_clk);
      chk(remData, 8'hc3);
      $display("t_upd done");
   endtask : t_upd
   task automatic t_test;
      axiW(RT_C_TEST, {16'h0, 8'h85, RT_TC_SINGLE});
      cmd(RT_OP_TEST, 8'h0, 8'h0);
      waitTest;
      chk(testActive, 1'h1);
      chk(testTx, 1'h1);
      chk(testChannel, 7'h05);
      chk(radioPwr, RT_PWR_0DBM);
      axiW(RT_C_TEST, {16'h0, 8'h0a, RT_TC_SWEEP});
      cmd(RT_OP_TEST, 8'h0, 8'h0);
      @(posedge sys_clk) linkLost <= 1'h1;
      @(posedge sys_clk) linkLost <= 1'h0;
      linkFound <= 1'h1;
      ce <= 1'h0;
      @(posedge sys_clk) linkFound <= 1'h0;
      ce <= 1'h1;
      repeat (300) @(posedge sys_clk);
      chk(testChannel, 7'h05);
      chk(testActive, 1'h1);
      $display("t_test done");
   endtask : t_test
   task automatic t_sweep;
      @(posedge sys_clk) arst_n <= 1'h0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'h1;
      repeat (5) @(posedge sys_clk);
      chk(testActive, 1'h0);
      axiW(RT_C_TEST, {16'h0, 8'h00, RT_TC_SWEEP});
      cmd(RT_OP_TEST, 8'h0, 8'h0);
      waitTest;
      chk(testTx, 1'h0);
      c = testChannel;
      for (int i = 0; i < 120 && testChannel === c; i++) @(posedge sys_clk);
      c = testChannel;
      repeat (99) @(posedge sys_clk);
      chk(testChannel, c);
      @(posedge sys_clk);
      chk(testChannel, 7'(c + 7'h1));
      $display("t_sweep done");
   endtask : t_sweep
   task automatic give_verdict;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'h1;
      repeat (5) @(posedge sys_clk);
      t_regs;
      t_upd;
      t_test;
      t_sweep;
      give_verdict;
   end
   initial begin
      #300us;
      fails++;
      give_verdict;
   end
endmodule : testbench
